// [include/dsl_pkg.sv]
// shared constants and types of the serial load port
package dsl_pkg;
  // ----------------------------------------
  // frame geometry
  // ----------------------------------------
  localparam int unsigned WORD_BITS  = 32;
  localparam int unsigned SHORT_BITS = 24;
  localparam int unsigned CNT_W      = 5;
  localparam logic [4:0]  SHORT_CNT  = 5'h18;
  localparam logic [4:0]  FULL_CNT   = 5'h00;
  // ----------------------------------------
  // command word fields
  // ----------------------------------------
  localparam int unsigned DATA_LSB   = 0;
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned ADDR_LSB   = 16;
  localparam int unsigned ADDR_W     = 4;
  localparam int unsigned CH_NUM     = 5;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [15:0] CODE_RST   = 16'h0000;
  localparam logic [31:0] WORD_RST   = 32'h0000_0000;

  typedef struct packed {
    logic [31:0] word;
    logic        short24;
  } dsl_cmd_s;
endpackage : dsl_pkg

// [design/dsl_port.sv]
// serial load port: shift register, echo output, command capture and update strobe
// How it works
// - sample data on clock rise while selected
// - accept 24, 32 or multiple-of-32 bit frames
// - echo each bit 32 rises later, falling edge
// - echo output undriven while select is high
// - shift and drive echo while select low
// - select rise stops shifting, executes command if frame length is valid, else flags len_err
// - update strobe fall copies all input registers
// - update strobe ignored while select is low
// - update acts independent of serial clock
`timescale 1ns/10ps
module dsl_port
  import dsl_pkg::*;
#(
  parameter int unsigned CH  = CH_NUM,
  parameter int unsigned DW  = DATA_W
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             sclk,
  input  wire logic             sdi,
  input  wire logic             select_load_n,
  input  wire logic             async_update_n,
  output logic                  sdo,
  output logic                  sdo_oe,
  output dsl_cmd_s              cmd,
  output logic                  cmd_valid,
  output logic                  len_err,
  output logic [CH*DW-1:0]      dac_code
);
  // ----------------------------------------
  // link domain
  // ----------------------------------------
  logic [WORD_BITS-1:0] shift_r;
  logic                 hold_r;
  logic                 sdo_r;
  logic [CNT_W-1:0]     cnt_r;
  logic                 full_r;
  logic [CNT_W-1:0]     cnt_nxt;
  logic                 full_nxt;
  logic                 len_ok_r;
  logic                 long_r;

  // select high freezes the link side; the clock may stop outside frames
  always_ff @(posedge sclk) begin
    if (!select_load_n) begin
      shift_r <= {shift_r[WORD_BITS-2:0], sdi};
      hold_r  <= shift_r[WORD_BITS-1];
    end
  end

  always_ff @(posedge sclk or posedge select_load_n) begin
    if (select_load_n) begin
      cnt_r  <= '0;
      full_r <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 5'h01;
      if (cnt_r == 5'h1f) begin
        full_r <= 1'b1;
      end
    end
  end

  assign cnt_nxt  = cnt_r + 5'h01;
  assign full_nxt = full_r | (cnt_r == 5'h1f);

  // counter is wiped by select rise, so the verdict is kept here
  // limitation: a frame with no clock edges reuses the last verdict
  always_ff @(posedge sclk) begin
    if (!select_load_n) begin
      len_ok_r <= ((cnt_nxt == SHORT_CNT) && !full_nxt) || ((cnt_nxt == FULL_CNT) && full_nxt);
      long_r   <= full_nxt;
    end
  end

  always_ff @(negedge sclk or posedge select_load_n) begin
    if (select_load_n) begin
      sdo_r <= 1'b0;
    end else begin
      sdo_r <= hold_r;
    end
  end

  assign sdo = sdo_r;

  // ----------------------------------------
  // system domain synchronisers
  // ----------------------------------------
  logic sel_s1_r, sel_s2_r, sel_d_r;
  logic upd_s1_r, upd_s2_r, upd_d_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      sel_s1_r <= 1'b1;
      sel_s2_r <= 1'b1;
      sel_d_r  <= 1'b1;
      upd_s1_r <= 1'b1;
      upd_s2_r <= 1'b1;
      upd_d_r  <= 1'b1;
    end else begin
      sel_s1_r <= select_load_n;
      sel_s2_r <= sel_s1_r;
      sel_d_r  <= sel_s2_r;
      upd_s1_r <= async_update_n;
      upd_s2_r <= upd_s1_r;
      upd_d_r  <= upd_s2_r;
    end
  end

  logic sel_rise;
  logic upd_fire;
  logic len_ok;
  assign sel_rise = sel_s2_r & ~sel_d_r;
  // gated by select only; a host not using it holds it high
  assign upd_fire = upd_d_r & ~upd_s2_r & sel_s2_r;
  // link state is quiescent once select has been high two cycles
  assign len_ok   = len_ok_r;

  // ----------------------------------------
  // echo enable
  // ----------------------------------------
  logic sdo_oe_r;
  always_ff @(posedge clk) begin
    if (srst) begin
      sdo_oe_r <= 1'b0;
    end else begin
      sdo_oe_r <= ~sel_s2_r;
    end
  end
  assign sdo_oe = sdo_oe_r;

  // ----------------------------------------
  // command capture
  // ----------------------------------------
  dsl_cmd_s cmd_r;
  logic     cmd_valid_r;
  logic     len_err_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      cmd_r       <= '{word: WORD_RST, short24: 1'b0};
      cmd_valid_r <= 1'b0;
      len_err_r   <= 1'b0;
    end else begin
      cmd_valid_r <= sel_rise & len_ok;
      len_err_r   <= sel_rise & ~len_ok;
      if (sel_rise & len_ok) begin
        cmd_r.word    <= long_r ? shift_r : {8'h00, shift_r[SHORT_BITS-1:0]};
        cmd_r.short24 <= ~long_r;
      end
    end
  end
  assign cmd       = cmd_r;
  assign cmd_valid = cmd_valid_r;
  assign len_err   = len_err_r;

  // ----------------------------------------
  // input and converter registers
  // ----------------------------------------
  logic [DW-1:0]     in_r  [CH];
  logic [CH*DW-1:0]  dac_r;
  logic [ADDR_W-1:0] addr;
  assign addr = cmd_r.word[ADDR_LSB +: ADDR_W];

  // command decoding is kept to a plain write of the addressed input register
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < CH; i++) begin
        in_r[i] <= CODE_RST;
      end
    end else if (cmd_valid_r) begin
      for (int i = 0; i < CH; i++) begin
        if (addr == ADDR_W'(i)) begin
          in_r[i] <= cmd_r.word[DATA_LSB +: DW];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      dac_r <= '0;
    end else if (upd_fire) begin
      for (int i = 0; i < CH; i++) begin
        dac_r[i*DW +: DW] <= in_r[i];
      end
    end
  end
  assign dac_code = dac_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [CH*DW-1:0] in_flat;
  always_comb begin
    in_flat = '0;
    for (int i = 0; i < CH; i++) begin
      in_flat[i*DW +: DW] = in_r[i];
    end
  end

  sequence s_frame_end;
    $rose(sel_s2_r) ##0 len_ok;
  endsequence

  sequence s_update_req;
    $fell(upd_s2_r) ##0 sel_s2_r;
  endsequence

  chk_shift_sample: assert property (@(posedge sclk) disable iff (select_load_n)
    1'b1 |=> shift_r[0] == $past(sdi))
    else $error("input bit not sampled");
  chk_echo_delay: assert property (@(posedge sclk) disable iff (select_load_n)
    (shift_r[WORD_BITS-1] |=> hold_r) and (!shift_r[WORD_BITS-1] |=> !hold_r))
    else $error("echo bit out of step");
  chk_oe_off: assert property (@(posedge clk) disable iff (srst)
    sel_s2_r |=> !sdo_oe)
    else $error("echo driven while deselected");
  chk_oe_on: assert property (@(posedge clk) disable iff (srst)
    !sel_s2_r |=> sdo_oe)
    else $error("echo not driven while selected");
  chk_exec_pulse: assert property (@(posedge clk) disable iff (srst)
    s_frame_end |=> cmd_valid ##1 !cmd_valid)
    else $error("command not executed once");
  chk_bad_len: assert property (@(posedge clk) disable iff (srst)
    ($rose(sel_s2_r) && !len_ok) |=> len_err && !cmd_valid)
    else $error("bad frame length accepted");
  chk_last_word: assert property (@(posedge clk) disable iff (srst)
    (s_frame_end ##0 long_r) |=> cmd.word == $past(shift_r))
    else $error("executed word not last 32 bits");
  chk_update_copy: assert property (@(posedge clk) disable iff (srst)
    s_update_req |=> dac_code == $past(in_flat))
    else $error("update did not copy inputs");
  chk_update_gate: assert property (@(posedge clk) disable iff (srst)
    !$stable(dac_code) |-> $past(upd_fire) && $past(sel_s2_r))
    else $error("converter changed without gated update");
endmodule : dsl_port

// [bench/dsl_host.sv]
// serial host model: frames bits onto the load port and captures the echo
`timescale 1ns/10ps
module dsl_host (
  output logic      sclk,
  output logic      sdi,
  output logic      select_load_n,
  input  wire logic sdo
);
  initial begin
    sclk = 1'b0;
    sdi = 1'b0;
    select_load_n = 1'b1;
  end
  // clock stands still outside frames; sdi flips on release, not held
  task automatic send(input logic [63:0] d, input int n, output logic [31:0] echo);
    echo = 32'h0;
    select_load_n = 1'b0;
    #80;
    for (int i = n - 1; i >= 0; i--) begin
      sdi = d[i];
      #79 sclk = 1'b1;
      #80 sclk = 1'b0;
      // echo launches on this fall; look once it has settled
      #1 if (n - i > 32) echo = {echo[30:0], sdo};
    end
    #80 sdi = ~sdi;
    select_load_n = 1'b1;
    #160;
  endtask : send
endmodule : dsl_host

// [bench/dsl_port_tb.sv]
// self-checking bench of the serial load port
`timescale 1ns/10ps
module dsl_port_tb;
  import dsl_pkg::*;
  logic        clk = 0, srst = 1, async_update_n = 1;
  wire         sclk, sdi, sel_n, sdo, sdo_oe, cmd_valid, len_err;
  dsl_cmd_s    cmd;
  logic [79:0] dac_code, exp_dac = '0;
  logic [31:0] seed = 32'h863d7435, w, e, w1;
  logic [33:0] notes[$];
  int          error_cnt = 0, samples_checked = 0;
  always #2.5 clk = ~clk;
  dsl_host host_inst (.sclk(sclk), .sdi(sdi), .select_load_n(sel_n), .sdo(sdo));
  dsl_port dsl_port_inst (.clk(clk), .srst(srst), .sclk(sclk), .sdi(sdi), .select_load_n(sel_n),
    .async_update_n(async_update_n), .sdo(sdo), .sdo_oe(sdo_oe), .cmd(cmd), .cmd_valid(cmd_valid),
    .len_err(len_err), .dac_code(dac_code));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic check(input logic [79:0] got, input logic [79:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : check
  task automatic final_report();
    $display("mismatches %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  // oldest note meets each result pulse
  always @(posedge clk) if (cmd_valid || len_err)
    check({len_err, len_err ? 33'h0 : cmd}, notes.size() ? notes.pop_front() : '1);
  task automatic frame(input logic [63:0] d, input int n, input logic [33:0] note);
    notes.push_back(note);
    host_inst.send(d, n, e);
    for (int k = 0; k < 400 && notes.size() != 0; k++) @(posedge clk);
    if (notes.size() != 0) begin
      error_cnt++;
      final_report();
    end
    repeat (3) @(posedge clk);
  endtask : frame
  task automatic update();
    @(posedge clk) async_update_n <= 1'b0;
    repeat (4) @(posedge clk);
    async_update_n <= 1'b1;
    repeat (4) @(posedge clk);
    check(dac_code, exp_dac);
  endtask : update
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    repeat (5) @(posedge clk);
    for (int c = 0; c < 5; c++) begin
      w = {12'h0, 4'(c), 16'(xs())};
      exp_dac[c*16+:16] = w[15:0];
      frame(64'(w), 32, {1'b0, w, 1'b0});
    end
    check(80'(sdo_oe), 80'h0);
    update();
    w = 32'h0 | xs() & 32'hffff;
    exp_dac[15:0] = w[15:0];
    frame(64'(w), 24, {9'h0, w[23:0], 1'b1});
    w1 = xs();
    w = {12'h0, 4'h3, 16'(xs())};
    exp_dac[63:48] = w[15:0];
    frame({w1, w}, 64, {1'b0, w, 1'b0});
    check(80'(e), 80'(w1));
    frame(64'(xs()), 20, 34'h2_0000_0000);
    frame(64'(xs()), 33, 34'h2_0000_0000);
    update();
    w = {12'h0, 4'h4, 16'(xs())};
    fork
      frame(64'(w), 32, {1'b0, w, 1'b0});
      begin
        #2000 @(posedge clk) async_update_n <= 1'b0;
        check(80'(sdo_oe), 80'h1);
        repeat (6) @(posedge clk);
        async_update_n <= 1'b1;
      end
    join
    check(dac_code, exp_dac);
    exp_dac[79:64] = w[15:0];
    update();
    final_report();
  end
endmodule : dsl_port_tb
